// file: design/tofdc_ctrl.sv
// Host-side sequencer and depth/confidence datapath for a two-tap ToF sensor
// Assumes digitised pair outputs arrive synchronous to clk during readout
// Functional notes
// RL1: Four measurements, phases 0,180,90,270 in order
// RL2: Light on in integration, off for cooldown; illum_en is registered from integ and stays on through the one-cycle cooldown
// RL3: Two taps give eight values per pixel
// RL4: Each output pair carries one pixel's taps
// RL5: Tap swap alternates every eight columns
// RL6: Mix reference driven differentially during integration
// RL7: Pulse train then dark phase per period
// RL8: Integration and cooldown split period by fraction
// RL9: Modulation duty cycle is fifty percent
// RL10: Quadratures and norm per tap
// RL11: Averaged quadratures x and y
// RL12: Phase in degrees from x, y sign
// RL13: Confidence is sum of tap norms
// RL14: Mix inputs low at reset and readout
// RL15: Zero norm gives zero phase
// RL16: Eight values in, fixed-latency valid out
`timescale 1ns/100ps
`include "tofdc_defines.svh"
module tofdc_ctrl
	import tofdc_pkg::*;
(
	input  wire logic        clk,            // System clock
	input  wire logic        nrst,           // Async reset
	input  wire logic        start,          // Begin a depth sample
	input  wire logic        core_reset_fall,// Sensor reset falling edge window
	input  wire logic        shutter_fall,   // Shutter falling edge window
	input  wire logic [8:0]  column,         // Column being read
	input  wire logic        read_valid,     // Digitised pair sample valid
	input  wire logic        read_last,      // Last pixel of readout
	input  wire logic [15:0] pair_a_pos_out, // Digitised pair A positive
	input  wire logic [15:0] pair_a_neg_out, // Digitised pair A negative
	input  wire logic [15:0] pair_b_pos_out, // Digitised pair B positive
	input  wire logic [15:0] pair_b_neg_out, // Digitised pair B negative
	input  wire logic        pix_valid,      // Eight-value set valid
	output logic             pix_ready,      // Set accepted
	input  wire logic [127:0] pix_data,      // S0 0/180/90/270 then S1
	output logic             mix_ref_p,      // Mix reference positive
	output logic             mix_ref_n,      // Mix reference negative
	output logic             illum_en,       // Light source enable
	output logic [1:0]       phase_idx,      // Current phase step
	output logic             busy,           // Sequence running
	output logic [15:0] tap0_a,              // Pair A tap zero sample
	output logic [15:0] tap1_a,              // Pair A tap one sample
	output logic [15:0] tap0_b,              // Pair B tap zero sample
	output logic [15:0] tap1_b,              // Pair B tap one sample
	output logic        tap_valid,           // Tap samples valid
	output logic [15:0] phase_deg,           // Phase, degrees 9.7 fixed
	output logic [17:0] confidence,          // N0 + N1
	output logic        res_valid            // Result strobe
);
	tofdc_state_t state;
	tofdc_state_t next_state;
	logic [31:0]  tcnt;
	logic [7:0]   mcnt;
	logic         mod_clk;
	// Sequencer
	wire period_end = (tcnt == 32'(`TOFDC_PERIOD_CYC - 1));
	wire integ_end  = (tcnt == 32'(`TOFDC_INT_CYC - 1)); // RL8
	always_comb
	begin
		next_state = state;
		case (state)
			TOFDC_IDLE:  if (start) next_state = TOFDC_INTEG;
			TOFDC_INTEG: if (integ_end) next_state = TOFDC_COOL; // RL7
			TOFDC_COOL:  next_state = TOFDC_READ;
			TOFDC_READ:  if (period_end) next_state = (phase_idx == 2'd3) ? TOFDC_DONE : TOFDC_INTEG;
			TOFDC_DONE:  next_state = TOFDC_IDLE;
			default:     next_state = TOFDC_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state     <= TOFDC_IDLE;
			tcnt      <= '0;
			phase_idx <= '0;
		end
		else
		begin
			state <= next_state;
			if (state == TOFDC_IDLE || period_end)
				tcnt <= '0;
			else
				tcnt <= tcnt + 32'd1;
			if (state == TOFDC_IDLE)
				phase_idx <= '0;
			else if (state == TOFDC_READ && period_end)
				phase_idx <= phase_idx + 2'd1; // RL1
		end
	end
	assign busy = (state != TOFDC_IDLE);
	// Phase offset per step 0,180,90,270: offset in clock cycles, half a mod period being 180
	wire [7:0] ph_off = (phase_idx == 2'd0) ? 8'h00 :
		(phase_idx == 2'd1) ? 8'(`TOFDC_MOD_HALF_CYC) :
		(phase_idx == 2'd2) ? 8'(`TOFDC_MOD_HALF_CYC / 2) :
		8'(`TOFDC_MOD_HALF_CYC + `TOFDC_MOD_HALF_CYC / 2); // RL1
	wire integ = (state == TOFDC_INTEG);
	// Offset is added, not loaded: the phase step changes as integration starts
	wire [7:0] mod_per = 8'(2 * `TOFDC_MOD_HALF_CYC);
	wire [7:0] msum    = mcnt + ph_off;
	wire [7:0] mpos    = (msum >= mod_per) ? (msum - mod_per) : msum;
	// Equal half periods keep duty at 50%
	assign mod_clk = (mpos < 8'(`TOFDC_MOD_HALF_CYC)); // RL9
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			mcnt <= '0;
		else if (!integ || mcnt == mod_per - 8'd1)
			mcnt <= '0;
		else
			mcnt <= mcnt + 8'd1; // RL1
	end
	// Mix pins forced to 00 outside integration and on reset/shutter falls
	wire mix_quiet = !integ || core_reset_fall || shutter_fall; // RL14
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mix_ref_p <= 1'b0;
			mix_ref_n <= 1'b0;
			illum_en  <= 1'b0;
		end
		else
		begin
			mix_ref_p <= !mix_quiet && mod_clk;   // RL6
			mix_ref_n <= !mix_quiet && !mod_clk;  // RL6
			illum_en  <= integ;                   // RL2
		end
	end
	// Readout: tap order swaps on odd groups of eight columns
	wire odd_grp = column[3]; // RL5
	wire rd_ok   = (state == TOFDC_READ) && read_valid; // RL2
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tap0_a <= '0;
			tap1_a <= '0;
			tap0_b <= '0;
			tap1_b <= '0;
			tap_valid <= 1'b0;
		end
		else
		begin
			tap_valid <= rd_ok;
			if (rd_ok)
			begin
				tap0_a <= odd_grp ? pair_a_pos_out : pair_a_neg_out; // RL4
				tap1_a <= odd_grp ? pair_a_neg_out : pair_a_pos_out; // RL5
				tap0_b <= odd_grp ? pair_b_neg_out : pair_b_pos_out; // RL5
				tap1_b <= odd_grp ? pair_b_pos_out : pair_b_neg_out; // RL4
			end
		end
	end
	// Input buffer for pixel sets; ready back-pressures the source
	logic         f_valid;
	logic [127:0] f_data;
	tofdc_fifo #(.WIDTH(128), .DEPTH(`TOFDC_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.in_data   (pix_data),
		.out_valid (f_valid),
		.out_ready (1'b1),
		.out_data  (f_data)
	); // RL16
	// Stage 1: quadratures and norms
	wire signed [16:0] s00 = {1'b0, f_data[15:0]};
	wire signed [16:0] s01 = {1'b0, f_data[31:16]};
	wire signed [16:0] s02 = {1'b0, f_data[47:32]};
	wire signed [16:0] s03 = {1'b0, f_data[63:48]};
	wire signed [16:0] s10 = {1'b0, f_data[79:64]};
	wire signed [16:0] s11 = {1'b0, f_data[95:80]};
	wire signed [16:0] s12 = {1'b0, f_data[111:96]};
	wire signed [16:0] s13 = {1'b0, f_data[127:112]};
	wire signed [16:0] x0 = s00 - s01;   // RL10
	wire signed [16:0] y0 = s03 - s02;   // RL10
	wire signed [16:0] x1 = s10 - s11;
	wire signed [16:0] y1 = s13 - s12;
	wire [16:0] ax0 = x0[16] ? 17'(-x0) : 17'(x0);
	wire [16:0] ay0 = y0[16] ? 17'(-y0) : 17'(y0);
	wire [16:0] ax1 = x1[16] ? 17'(-x1) : 17'(x1);
	wire [16:0] ay1 = y1[16] ? 17'(-y1) : 17'(y1);
	logic signed [16:0] r_x0, r_y0, r_x1, r_y1;
	logic [17:0]        r_n0, r_n1;
	logic [2:0]         vpipe;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			r_x0 <= '0;
			r_y0 <= '0;
			r_x1 <= '0;
			r_y1 <= '0;
			r_n0 <= '0;
			r_n1 <= '0;
		end
		else if (f_valid)
		begin
			r_x0 <= x0;
			r_y0 <= y0;
			r_x1 <= x1;
			r_y1 <= y1;
			r_n0 <= {1'b0, ax0} + {1'b0, ay0}; // RL10
			r_n1 <= {1'b0, ax1} + {1'b0, ay1}; // RL10
		end
	end
	// Stage 2: x, y in Q1.14; division kept combinational for fixed latency
	wire nzero = (r_n0 == '0) || (r_n1 == '0); // RL15
	wire signed [33:0] q_x0 = nzero ? 34'sd0 : ($signed({r_x0, 13'h0}) / $signed({16'h0, r_n0}));
	wire signed [33:0] q_x1 = nzero ? 34'sd0 : ($signed({r_x1, 13'h0}) / $signed({16'h0, r_n1}));
	wire signed [33:0] q_y0 = nzero ? 34'sd0 : ($signed({r_y0, 13'h0}) / $signed({16'h0, r_n0}));
	wire signed [33:0] q_y1 = nzero ? 34'sd0 : ($signed({r_y1, 13'h0}) / $signed({16'h0, r_n1}));
	logic signed [17:0] ax, ay;
	logic               r_nz;
	logic [17:0]        r_conf;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ax     <= '0;
			ay     <= '0;
			r_nz   <= 1'b0;
			r_conf <= '0;
		end
		else
		begin
			ax     <= 18'(q_x0 - q_x1); // RL11
			ay     <= 18'(q_y0 - q_y1); // RL11
			r_nz   <= nzero;
			r_conf <= r_n0 + r_n1;      // RL13
		end
	end
	// Stage 3: phase = 90*(1-x) or 90*(3+x), x in Q.14 -> degrees 9.7; 360 needs nine integer bits
	wire signed [31:0] one_q = 32'sh4000;
	wire signed [31:0] xq    = 32'(ax);
	wire signed [31:0] base  = ay[17] ? (one_q - xq) : (3 * one_q + xq); // RL12
	wire signed [31:0] degq  = 32'(base * `TOFDC_DEG_SCALE);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			phase_deg  <= '0;
			confidence <= '0;
			vpipe      <= '0;
		end
		else
		begin
			vpipe      <= {vpipe[1:0], f_valid}; // RL16
			phase_deg  <= r_nz ? 16'h0000 : degq[22:7]; // RL15
			confidence <= r_conf;                      // RL13
		end
	end
	assign res_valid = vpipe[2];
	// Lit-cycle count; lets the integration length be asserted
	logic [31:0] lit_cnt;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			lit_cnt <= '0;
		else if (illum_en)
			lit_cnt <= lit_cnt + 32'd1;
		else
			lit_cnt <= '0;
	end
	chk_mix_quiet_read: assert property (@(posedge clk) disable iff (!nrst) // RL14
		$past(state) == TOFDC_READ |-> !mix_ref_p && !mix_ref_n) else $error("mix active in readout");
	chk_mix_forced_low: assert property (@(posedge clk) disable iff (!nrst) // RL14
		core_reset_fall || shutter_fall |=> !mix_ref_p && !mix_ref_n) else $error("mix active at forced edge");
	chk_mix_diff_integ: assert property (@(posedge clk) disable iff (!nrst) // RL6
		$past(integ) && !$past(mix_quiet) |-> mix_ref_p != mix_ref_n) else $error("mix not differential");
	chk_illum_off_read: assert property (@(posedge clk) disable iff (!nrst) // RL2
		state == TOFDC_READ |-> !illum_en) else $error("light on in readout");
	chk_light_len: assert property (@(posedge clk) disable iff (!nrst) // RL8
		$fell(illum_en) |-> lit_cnt == 32'(`TOFDC_INT_CYC)) else $error("integration length wrong");
	chk_read_after_cool: assert property (@(posedge clk) disable iff (!nrst) // RL7
		state == TOFDC_READ |-> $past(state) == TOFDC_COOL || $past(state) == TOFDC_READ)
		else $error("readout without dark phase");
	chk_phase_order: assert property (@(posedge clk) disable iff (!nrst) // RL1
		state == TOFDC_READ && period_end && phase_idx != 2'd3 |=> phase_idx == $past(phase_idx) + 2'd1)
		else $error("phase step skipped");
	chk_phase_restart: assert property (@(posedge clk) disable iff (!nrst) // RL1
		state == TOFDC_IDLE |=> phase_idx == 2'd0) else $error("phase not restarted");
	chk_result_latency: assert property (@(posedge clk) disable iff (!nrst) // RL16
		f_valid |-> ##3 res_valid) else $error("result latency wrong");
	chk_result_origin: assert property (@(posedge clk) disable iff (!nrst) // RL16
		res_valid |-> $past(f_valid, 3)) else $error("result without input");
	chk_zero_norm: assert property (@(posedge clk) disable iff (!nrst) // RL15
		f_valid && ((ax0 + ay0 == 0) || (ax1 + ay1 == 0)) |-> ##3 phase_deg == 16'h0000)
		else $error("zero norm phase nonzero");
	chk_conf_sum: assert property (@(posedge clk) disable iff (!nrst) // RL13
		f_valid |-> ##3 confidence == $past({1'b0,ax0}+{1'b0,ay0}+{1'b0,ax1}+{1'b0,ay1}, 3))
		else $error("confidence not norm sum");
	chk_tap_swap: assert property (@(posedge clk) disable iff (!nrst) // RL5
		rd_ok && odd_grp |=> tap0_a == $past(pair_a_pos_out)) else $error("tap swap wrong");
	chk_tap_even: assert property (@(posedge clk) disable iff (!nrst) // RL5
		rd_ok && !odd_grp |=> tap0_a == $past(pair_a_neg_out)) else $error("even group tap wrong");
	chk_no_read_integ: assert property (@(posedge clk) disable iff (!nrst) // RL2
		integ |=> !tap_valid) else $error("readout during integration");
endmodule : tofdc_ctrl

// file: design/tofdc_defines.svh
// Timing counts and arithmetic constants for the depth/confidence controller
// Assumes a 100 MHz system clock
`ifndef TOFDC_DEFINES_SVH
`define TOFDC_DEFINES_SVH
`define TOFDC_CLK_NS        10
`define TOFDC_PERIOD_NS     10000
`define TOFDC_PERIOD_CYC    (`TOFDC_PERIOD_NS / `TOFDC_CLK_NS)
`define TOFDC_PULSE_PCT     50
`define TOFDC_INT_CYC       ((`TOFDC_PERIOD_CYC * `TOFDC_PULSE_PCT) / 100)
`define TOFDC_MOD_NS        50
`define TOFDC_MOD_HALF_CYC  ((`TOFDC_MOD_NS / `TOFDC_CLK_NS) / 2)
`define TOFDC_PH0_DEG       0
`define TOFDC_PH180_DEG     180
`define TOFDC_PH90_DEG      90
`define TOFDC_PH270_DEG     270
`define TOFDC_DEG_SCALE     90
`define TOFDC_FIFO_DEPTH    16
`define TOFDC_SAMPLE_W      16
`define TOFDC_GROUP_W       8
`define TOFDC_LATENCY       3
`endif

// file: design/tofdc_pkg.sv
// Types for the depth/confidence controller
package tofdc_pkg;
	typedef enum logic [2:0]
	{
		TOFDC_IDLE   = 3'b000,
		TOFDC_INTEG  = 3'b001,
		TOFDC_COOL   = 3'b010,
		TOFDC_READ   = 3'b011,
		TOFDC_DONE   = 3'b100
	} tofdc_state_t;
endpackage : tofdc_pkg

// file: design/tofdc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
// Assumes a single clock, asynchronous active-low reset
`timescale 1ns/100ps
module tofdc_fifo #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 16
)(
	input  wire logic             clk,     // System clock
	input  wire logic             nrst,    // Async reset
	input  wire logic             in_valid,// Write request
	output logic                  in_ready,// Space available
	input  wire logic [WIDTH-1:0] in_data, // Write data
	output logic                  out_valid,// Data available
	input  wire logic             out_ready,// Read accept
	output logic      [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;
	wire              do_wr = in_valid && in_ready;
	wire              do_rd = out_valid && out_ready;
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rptr];
	always_ff @(posedge clk)
		if (do_wr)
			mem[wptr] <= in_data;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end
		else
		begin
			if (do_wr)
				wptr <= wptr + 1'b1;
			if (do_rd)
				rptr <= rptr + 1'b1;
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
	chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (!nrst)
		count <= (AW+1)'(DEPTH)) else $error("fifo count exceeds depth");
endmodule : tofdc_fifo

// file: testbench/tofdc_sensor.sv
// Behavioural two-tap sensor array seen through its digitisers
// Assumes the controller lights the scene once per phase and reads in the dark
`timescale 1ns/100ps
module tofdc_sensor
(
	input  wire logic        clk,            // System clock
	input  wire logic        nrst,           // Async reset
	input  wire logic        illum_en,       // Light source enable
	output logic [8:0]       column,         // Column on the pairs
	output logic             read_valid,     // Pair sample valid
	output logic             read_last,      // Last pixel
	output logic [15:0]      pair_a_pos_out, // Pair A positive
	output logic [15:0]      pair_a_neg_out, // Pair A negative
	output logic [15:0]      pair_b_pos_out, // Pair B positive
	output logic [15:0]      pair_b_neg_out  // Pair B negative
);
	logic       lit;
	logic [3:0] cnt;
	logic [7:0] seq;
	wire        rd = (cnt == 4'h7) || (cnt == 4'h8);

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			{lit, cnt, seq, column, read_valid, read_last} <= '0;
			{pair_a_pos_out, pair_a_neg_out, pair_b_pos_out, pair_b_neg_out} <= '0;
		end
		else
		begin
			lit <= illum_en;
			cnt <= (lit && !illum_en) ? 4'h1 : ((cnt != 4'h0) ? cnt + 4'h1 : 4'h0);
			read_valid <= rd;
			read_last <= (cnt == 4'h8);
			column <= (cnt == 4'h7) ? 9'h008 : 9'h000;
			if (rd)
			begin
				seq <= seq + 8'h01;
				pair_a_pos_out <= {seq, 8'h11};
				pair_a_neg_out <= {seq, 8'h22};
				pair_b_pos_out <= {seq, 8'h33};
				pair_b_neg_out <= {seq, 8'h44};
			end
			else
			begin
				// Idle lines wander so stale data is never mistaken for a sample
				pair_a_pos_out <= ~pair_a_pos_out;
				pair_a_neg_out <= ~pair_a_neg_out;
				pair_b_pos_out <= ~pair_b_pos_out;
				pair_b_neg_out <= ~pair_b_neg_out;
			end
		end
endmodule : tofdc_sensor

// file: testbench/tof_depth_confidence_calc_bench.sv
// Self-checking bench for the depth/confidence controller
// Assumes the behavioural sensor model answers each readout window
`timescale 1ns/100ps
`include "tofdc_defines.svh"
module tof_depth_confidence_calc_bench;
	logic clk, nrst, start, core_reset_fall, shutter_fall, pix_valid, pix_ready;
	logic [127:0] pix_data;
	logic [8:0] column;
	logic read_valid, read_last, mix_ref_p, mix_ref_n, illum_en, busy, tap_valid, res_valid;
	logic [15:0] pair_a_pos_out, pair_a_neg_out, pair_b_pos_out, pair_b_neg_out;
	logic [15:0] tap0_a, tap1_a, tap0_b, tap1_b, phase_deg;
	logic [1:0] phase_idx;
	logic [17:0] confidence;
	logic [63:0] tap_exp;
	int miscompares, cmp_count, tap_n;

	tofdc_ctrl dut (.clk, .nrst, .start, .core_reset_fall, .shutter_fall, .column, .read_valid, .read_last,
		.pair_a_pos_out, .pair_a_neg_out, .pair_b_pos_out, .pair_b_neg_out, .pix_valid, .pix_ready, .pix_data,
		.mix_ref_p, .mix_ref_n, .illum_en, .phase_idx, .busy, .tap0_a, .tap1_a, .tap0_b, .tap1_b, .tap_valid,
		.phase_deg, .confidence, .res_valid);
	tofdc_sensor sensor (.clk, .nrst, .illum_en, .column, .read_valid, .read_last,
		.pair_a_pos_out, .pair_a_neg_out, .pair_b_pos_out, .pair_b_neg_out);

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done;
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// Three sets back to back; the last has a dead tap
	task automatic run_calc;
		logic [127:0] set[3] = '{{16'h0064, 64'h0, 16'h0064, 32'h0},
			{48'h0, 16'h0064, 32'h0, 16'h0064, 16'h0}, {112'h0, 16'h0032}};
		logic [15:0] ph[3] = '{16'h2d00, 16'h5a00, 16'h0000};
		logic [17:0] cf[3] = '{18'h000c8, 18'h000c8, 18'h00032};
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk);
			pix_valid <= (i < 3);
			pix_data <= set[i % 3];
			#1;
			check("pix ready", pix_ready, 1'b1);
			// One edge into the buffer, then the pipeline
			check("result strobe", res_valid, (i >= 1 + `TOFDC_LATENCY) && (i < 4 + `TOFDC_LATENCY));
			if (i >= 1 + `TOFDC_LATENCY && i < 4 + `TOFDC_LATENCY)
			begin
				check("phase", phase_deg, ph[i - 1 - `TOFDC_LATENCY]);
				check("confidence", confidence, cf[i - 1 - `TOFDC_LATENCY]);
			end
		end
	endtask : run_calc

	// Full four-phase sample with a stray start and two forcing windows
	task automatic run_seq;
		int on_c[4] = '{default: 0};
		int hi_c = 0;
		int k = 0;
		int stray = 0;
		logic was = 1'b0;
		@(posedge clk);
		start <= 1'b1;
		for (int n = 0; n < 4300; n++)
		begin
			@(posedge clk);
			start <= (n == 3990);
			shutter_fall <= (n >= 1200 && n < 1204);
			core_reset_fall <= (n >= 2200 && n < 2204);
			#1;
			if (n == 1203 || n == 2203) check("forced mix", {mix_ref_p, mix_ref_n}, 2'b00);
			if (illum_en && !was) check("phase step", phase_idx, k++);
			if (illum_en)
			begin
				on_c[phase_idx]++;
				if (phase_idx == 2'b00) hi_c += mix_ref_p;
				if (mix_ref_p === mix_ref_n && (n % 1000 < 200 || n % 1000 > 205)) stray++;
			end
			else if (mix_ref_p !== 1'b0 || mix_ref_n !== 1'b0)
				stray++;
			was = illum_en;
		end
		check("phase count", k, 4);
		check("busy at end", busy, 1'b0);
		check("mix stray cycles", stray, 0);
		for (int p = 0; p < 4; p++) check("light cycles", on_c[p], `TOFDC_INT_CYC);
		check("mix high cycles", hi_c, `TOFDC_INT_CYC / 2);
	endtask : run_seq

	// Taps land one cycle after each read, swapped per column group
	always @(posedge clk)
	begin
		if (tap_valid)
		begin
			check("tap samples", {tap0_a, tap1_a, tap0_b, tap1_b}, tap_exp);
			tap_n++;
		end
		if (read_valid)
			tap_exp <= column[3] ? {pair_a_pos_out, pair_a_neg_out, pair_b_neg_out, pair_b_pos_out}
				: {pair_a_neg_out, pair_a_pos_out, pair_b_pos_out, pair_b_neg_out};
	end

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (6000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial
	begin
		{nrst, start, core_reset_fall, shutter_fall, pix_valid} = '0;
		pix_data = '0;
		#1;
		check("reset outputs", {mix_ref_p, mix_ref_n, illum_en, busy, tap_valid, res_valid}, 6'h00);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		run_calc();
		run_seq();
		check("tap count", tap_n, 8);
		test_done();
	end
endmodule : tof_depth_confidence_calc_bench
